// ---- verilog/pwmts_core.sv ----
// One PWM channel's trigger, interrupt, sync chain and dead-time logic.
// Assumes rectifier PWM and sync sources come from logic on clk_sys.
// Notes on behaviour
// - Oversampling code 00 gives one sample trigger per period at count.
// - Codes 01, 10, 11 give two, four, eight triggers per period.
// - Extra triggers are spaced by period divided by the factor.
// - A processor interrupt is derived from the programmed period.
// - The period interrupt passes a divider, count up to 255.
// - Settings 1..15 map to the listed counts; fires every count+1.
// - The divided interrupt also starts the general converter.
// - Channels chain; slave enable and source select pick the master.
// - Equal edge settings on synced channels differ only by phase.
// - A detection window opens after a rectifier PWM falling edge seen while the detector is idle.
// - Window starts after a blanking delay, lasts a programmed length.
// - A capture timer counts sense-asserted time inside the window.
// - One cycle's measurement moves the next cycle's turn-off edge.
// - The two edge adjustments are signed accumulators reset to zero.
// - In automatic mode, each cycle each accumulator adds its signed step.
// - Automatic mode picks the step by comparing against thresholds.
// - Manual mode freezes updates; firmware writes the accumulators.
// - The selected sync input, when slave enable is set, resets the ramp counter.
// - Sync output fires when the counter meets the phase trigger.
// - A sample trigger fires when the trigger count equals the counter.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module pwmts_core import pwmts_pkg::*; #(
  parameter int CW = 14, // Ramp counter width
  parameter int AW = 16, // Accumulator width
  parameter int MW = 12 // Capture timer width
) (
  input wire logic clk_sys, // 200 MHz clock
  input wire logic reset, // Synchronous, active high
  input wire pwmts_bus_t bus, // Register request
  output logic [31:0] bus_rdata, // Read data, cycle after read
  input wire logic [3:0] sync_src_in, // Sync pulses of channels 0..3
  input wire logic rectifier_pwm_0, // Rectifier PWM A
  input wire logic rectifier_pwm_1, // Rectifier PWM B
  input wire logic conduction_sense_0, // Diode sense A, async pin
  input wire logic conduction_sense_1, // Diode sense B, async pin
  output logic sample_trig, // Error converter trigger pulse
  output logic sync_out, // Sync pulse to next channel
  output logic period_irq, // Divided period interrupt pulse
  output logic conv_start, // General converter start pulse
  output logic signed [AW-1:0] edge_adjust_acc_a, // Turn-off shift A
  output logic signed [AW-1:0] edge_adjust_acc_b // Turn-off shift B
);
  // Elaboration check on widths
  if (CW < 8 || CW > 16 || AW < 9 || MW < 8 || MW > 16) begin : g_chk
    $error("pwmts_core: unsupported width parameter");
  end
  logic [CTRL_W-1:0] ctrl;
  logic [CW-1:0] period, samp, phase, cnt;
  logic [7:0] blank, wlen, thr_lo, thr_hi, step;
  logic [1:0] os, src;
  logic slave_en, manual, sync_hit, pend, pb;
  logic [3:0] div_set;
  logic [7:0] div_cnt, div_lim;
  assign os = ctrl[CTRL_OS_LSB +: 2];
  assign div_set = ctrl[CTRL_DIV_LSB +: 4];
  assign slave_en = ctrl[CTRL_SLAVE_BIT];
  assign src = ctrl[CTRL_SRC_LSB +: 2];
  assign manual = ctrl[CTRL_MANUAL_BIT];
  assign div_lim = div_count(div_set);
  // Configuration register writes
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RST;
      period <= CW'(PERIOD_RST);
      samp <= CW'(SAMPLE_RST);
      phase <= CW'(PHASE_RST);
      blank <= BLANK_RST;
      wlen <= LEN_RST;
      thr_lo <= THR_LO_RST;
      thr_hi <= THR_HI_RST;
      step <= STEP_RST;
    end else if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CTRL: ctrl <= bus.wdata[CTRL_W-1:0];
        ADDR_PERIOD: period <= bus.wdata[CW-1:0];
        ADDR_SAMPLE: samp <= bus.wdata[CW-1:0];
        ADDR_PHASE: phase <= bus.wdata[CW-1:0];
        ADDR_DTCCFG: begin
          blank <= bus.wdata[7:0];
          wlen <= bus.wdata[DTC_LEN_LSB +: 8];
        end
        ADDR_THRESH: begin
          thr_lo <= bus.wdata[7:0];
          thr_hi <= bus.wdata[THR_HI_LSB +: 8];
          step <= bus.wdata[THR_STEP_LSB +: 8];
        end
        default: ;
      endcase
    end
  end
  // Ramp counter with sync restart
  assign sync_hit = slave_en && sync_src_in[src];
  assign pend = (cnt >= period);
  assign pb = pend || sync_hit;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= '0;
    end else if (sync_hit || pend) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end
  // Sync output at the phase trigger
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sync_out <= 1'b0;
    end else begin
      sync_out <= (cnt == phase);
    end
  end
  // Sample triggers with oversampling
  logic [CW:0] os_step, sc;
  logic [3:0] osn;
  logic [2:0] left;
  logic fire_first, fire_extra;
  assign os_step = ({1'b0, period} + (CW+1)'(1)) >> os;
  assign osn = 4'h1 << os;
  assign fire_first = (cnt == samp);
  assign fire_extra = (left != 3'h0) && (sc == '0);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sc <= '0;
      left <= 3'h0;
      sample_trig <= 1'b0;
    end else begin
      sample_trig <= fire_first || fire_extra;
      if (fire_first) begin
        left <= 3'(osn - 4'h1);
        sc <= os_step - (CW+1)'(1);
      end else if (left != 3'h0) begin
        if (sc == '0) begin
          left <= left - 3'h1;
          sc <= os_step - (CW+1)'(1);
        end else begin
          sc <= sc - (CW+1)'(1);
        end
      end
    end
  end
  // Period interrupt divider
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_cnt <= 8'h00;
      period_irq <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      period_irq <= 1'b0;
      conv_start <= 1'b0;
      if (bus.wr && bus.addr == ADDR_CTRL) begin
        div_cnt <= 8'h00;
      end else if (pb) begin
        if (div_cnt >= div_lim) begin
          div_cnt <= 8'h00;
          period_irq <= 1'b1;
          conv_start <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end
  // Sense pin synchronisers, change taken when stages two and three agree
  logic [1:0] s1, s2, s3, sense;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1 <= 2'b00;
      s2 <= 2'b00;
      s3 <= 2'b00;
      sense <= 2'b00;
    end else begin
      s1 <= {conduction_sense_1, conduction_sense_0};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 2; i++) begin
        if (s2[i] == s3[i]) begin
          sense[i] <= s3[i];
        end
      end
    end
  end
  // Detection window and capture timer per rectifier output
  pwmts_dtc_st_t st [2];
  logic [7:0] bt [2];
  logic [MW-1:0] meas [2];
  logic [1:0] pwm, pwm_q, fall, done;
  assign pwm = {rectifier_pwm_1, rectifier_pwm_0};
  assign fall = pwm_q & ~pwm;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pwm_q <= 2'b00;
      done <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        st[i] <= ST_IDLE;
        bt[i] <= 8'h00;
        meas[i] <= '0;
      end
    end else begin
      pwm_q <= pwm;
      done <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        unique case (st[i])
          ST_IDLE: if (fall[i]) begin
            st[i] <= ST_BLANK;
            bt[i] <= blank;
          end
          ST_BLANK: if (bt[i] == 8'h00) begin
            st[i] <= ST_WIN;
            bt[i] <= wlen;
            meas[i] <= '0;
          end else begin
            bt[i] <= bt[i] - 8'h01;
          end
          ST_WIN: begin
            if (sense[i] && meas[i] != '1) begin
              meas[i] <= meas[i] + MW'(1);
            end
            if (bt[i] == 8'h00) begin
              st[i] <= ST_IDLE;
              done[i] <= 1'b1;
            end else begin
              bt[i] <= bt[i] - 8'h01;
            end
          end
          default: st[i] <= ST_IDLE;
        endcase
      end
    end
  end
  // Signed step chosen from the measurement
  function automatic logic signed [AW-1:0] delta(input logic [MW-1:0] m,
      input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] s);
    logic signed [AW-1:0] sx;
    sx = AW'(signed'({1'b0, s}));
    if (m > MW'(hi)) delta = sx;
    else if (m < MW'(lo)) delta = -sx;
    else delta = '0;
  endfunction : delta
  // Edge adjustment accumulators
  logic signed [AW-1:0] acc [2];
  logic [1:0] adj_wr;
  assign adj_wr = {bus.wr && bus.addr == ADDR_ADJ_B,
                   bus.wr && bus.addr == ADDR_ADJ_A};
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc[0] <= '0;
      acc[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (manual) begin
          if (adj_wr[i]) begin
            acc[i] <= bus.wdata[AW-1:0];
          end
        end else if (done[i]) begin
          acc[i] <= acc[i] + delta(meas[i], thr_lo, thr_hi, step);
        end
      end
    end
  end
  assign edge_adjust_acc_a = acc[0];
  assign edge_adjust_acc_b = acc[1];
  // Register read port
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL: bus_rdata <= 32'(ctrl);
        ADDR_PERIOD: bus_rdata <= 32'(period);
        ADDR_SAMPLE: bus_rdata <= 32'(samp);
        ADDR_PHASE: bus_rdata <= 32'(phase);
        ADDR_DTCCFG: bus_rdata <= 32'({wlen, blank});
        ADDR_THRESH: bus_rdata <= 32'({step, thr_hi, thr_lo});
        ADDR_ADJ_A: bus_rdata <= 32'(unsigned'(acc[0]));
        ADDR_ADJ_B: bus_rdata <= 32'(unsigned'(acc[1]));
        ADDR_MON: bus_rdata <= (32'(meas[1]) << MON_B_LSB) | 32'(meas[0]);
        ADDR_COUNT: bus_rdata <= 32'(cnt);
        default: bus_rdata <= 32'h0000_0000;
      endcase
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end
  property p_trig_pos;
    @(posedge clk_sys) disable iff (reset) cnt == samp |=> sample_trig;
  endproperty
  a_trig_pos: assert property (p_trig_pos) else $error("no trigger");
  property p_os_single;
    @(posedge clk_sys) disable iff (reset)
      sample_trig && $past(os) == 2'b00 && $past(left) == 3'h0
      |-> $past(cnt) == $past(samp);
  endproperty
  a_os_single: assert property (p_os_single) else $error("extra trig");
  property p_irq_div;
    @(posedge clk_sys) disable iff (reset)
      period_irq |-> $past(pb) && $past(div_cnt) == $past(div_lim);
  endproperty
  a_irq_div: assert property (p_irq_div) else $error("bad divide");
  property p_conv;
    @(posedge clk_sys) disable iff (reset) period_irq == conv_start;
  endproperty
  a_conv: assert property (p_conv) else $error("start mismatch");
  property p_sync_rst;
    @(posedge clk_sys) disable iff (reset) sync_hit |=> cnt == '0;
  endproperty
  a_sync_rst: assert property (p_sync_rst) else $error("no restart");
  property p_sync_out;
    @(posedge clk_sys) disable iff (reset) cnt == phase |=> sync_out;
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("no sync");
  property p_fall;
    @(posedge clk_sys) disable iff (reset)
      fall[0] && st[0] == ST_IDLE
      |=> st[0] == ST_BLANK && bt[0] == $past(blank);
  endproperty
  a_fall: assert property (p_fall) else $error("no window");
  property p_win_clr;
    @(posedge clk_sys) disable iff (reset)
      st[0] == ST_BLANK && bt[0] == 8'h00 |=> st[0] == ST_WIN && meas[0] == '0;
  endproperty
  a_win_clr: assert property (p_win_clr) else $error("no clear");
  property p_acc_up;
    @(posedge clk_sys) disable iff (reset)
      done[0] && !manual && meas[0] > MW'(thr_hi)
      |=> acc[0] == $past(acc[0]) + AW'(signed'({1'b0, $past(step)}));
  endproperty
  a_acc_up: assert property (p_acc_up) else $error("bad step");
  property p_manual;
    @(posedge clk_sys) disable iff (reset)
      manual && !adj_wr[1] |=> $stable(acc[1]);
  endproperty
  a_manual: assert property (p_manual) else $error("acc moved");
endmodule : pwmts_core

// ---- verilog/pwmts_pkg.sv ----
// Shared constants and types for the PWM trigger, sync and dead-time block.
// Assumes one 200 MHz system clock and a word-addressed register port.
package pwmts_pkg;
  // Register word addresses
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PERIOD = 4'h1;
  localparam logic [3:0] ADDR_SAMPLE = 4'h2;
  localparam logic [3:0] ADDR_PHASE = 4'h3;
  localparam logic [3:0] ADDR_DTCCFG = 4'h4;
  localparam logic [3:0] ADDR_THRESH = 4'h5;
  localparam logic [3:0] ADDR_ADJ_A = 4'h6;
  localparam logic [3:0] ADDR_ADJ_B = 4'h7;
  localparam logic [3:0] ADDR_MON = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'h9;
  // Control register fields
  localparam int CTRL_OS_LSB = 0;
  localparam int CTRL_DIV_LSB = 2;
  localparam int CTRL_SLAVE_BIT = 6;
  localparam int CTRL_SRC_LSB = 7;
  localparam int CTRL_MANUAL_BIT = 9;
  localparam int CTRL_W = 10;
  // Field positions of the dead-time config, threshold and monitor registers
  localparam int DTC_LEN_LSB = 8;
  localparam int THR_HI_LSB = 8;
  localparam int THR_STEP_LSB = 16;
  localparam int MON_B_LSB = 16;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
  localparam logic [13:0] PERIOD_RST = 14'h03FF;
  localparam logic [13:0] SAMPLE_RST = 14'h0000;
  localparam logic [13:0] PHASE_RST = 14'h0000;
  localparam logic [7:0] BLANK_RST = 8'h04;
  localparam logic [7:0] LEN_RST = 8'h10;
  localparam logic [7:0] THR_LO_RST = 8'h02;
  localparam logic [7:0] THR_HI_RST = 8'h08;
  localparam logic [7:0] STEP_RST = 8'h01;
  // Dead-time detector states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BLANK = 2'b01,
    ST_WIN = 2'b10
  } pwmts_dtc_st_t;
  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } pwmts_bus_t;
  // Divider setting to divide count
  function automatic logic [7:0] div_count(input logic [3:0] s);
    unique case (s)
      4'h0, 4'h1: div_count = 8'h00;
      4'h2: div_count = 8'h01;
      4'h3: div_count = 8'h03;
      4'h4: div_count = 8'h07;
      4'h5: div_count = 8'h0F;
      4'h6: div_count = 8'h1F;
      4'h7: div_count = 8'h2F;
      4'h8: div_count = 8'h3F;
      4'h9: div_count = 8'h4F;
      4'hA: div_count = 8'h5F;
      4'hB: div_count = 8'h7F;
      4'hC: div_count = 8'h9F;
      4'hD: div_count = 8'hBF;
      4'hE: div_count = 8'hDF;
      4'hF: div_count = 8'hFF;
    endcase
  endfunction : div_count
endpackage : pwmts_pkg

// ---- tb/pwmts_drv_model.sv ----
// Behavioural rectifier gate driver: reports body diode conduction.
// Assumes the rectifier PWM level comes from logic on clk_sys.
`timescale 1ns/1ps
module pwmts_drv_model (
  input wire logic clk_sys, // Channel clock
  input wire logic rectifier_pwm, // Gate command for this rectifier
  input wire logic [7:0] cond_len, // Conduction cycles per turn-off
  output logic conduction_sense // High while body diode conducts
);
  logic pwm_q = 1'b0;
  logic [7:0] left = 8'h00;
  // Diode conducts from gate turn-off for the commanded time
  always @(posedge clk_sys) begin
    pwm_q <= rectifier_pwm;
    if (pwm_q && !rectifier_pwm) begin
      left <= cond_len;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  // Sense drops once the gate turns on again
  assign conduction_sense = (left != 8'h00) && !rectifier_pwm;
endmodule : pwmts_drv_model

// ---- tb/tb.sv ----
// Self-checking bench for pwmts_core: triggers, divider, sync, dead time.
// Assumes pwmts_drv_model stands in for both rectifier drivers.
`timescale 1ns/1ps
module tb import pwmts_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  pwmts_bus_t bus = '0;
  logic [31:0] bus_rdata;
  logic [3:0] sync_src_in = 4'h0;
  logic rectifier_pwm_0 = 1'b0;
  logic rectifier_pwm_1 = 1'b0;
  logic conduction_sense_0;
  logic conduction_sense_1;
  logic sample_trig;
  logic sync_out;
  logic period_irq;
  logic conv_start;
  logic signed [15:0] edge_adjust_acc_a;
  logic signed [15:0] edge_adjust_acc_b;
  logic [7:0] cond_a = 8'h00;
  logic [7:0] cond_b = 8'h00;
  logic [31:0] rd;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;

  pwmts_core dut_u (.clk_sys(clk_sys), .reset(reset), .bus(bus),
    .bus_rdata(bus_rdata), .sync_src_in(sync_src_in),
    .rectifier_pwm_0(rectifier_pwm_0), .rectifier_pwm_1(rectifier_pwm_1),
    .conduction_sense_0(conduction_sense_0),
    .conduction_sense_1(conduction_sense_1), .sample_trig(sample_trig),
    .sync_out(sync_out), .period_irq(period_irq), .conv_start(conv_start),
    .edge_adjust_acc_a(edge_adjust_acc_a),
    .edge_adjust_acc_b(edge_adjust_acc_b));
  pwmts_drv_model drv_a (.clk_sys(clk_sys), .rectifier_pwm(rectifier_pwm_0),
    .cond_len(cond_a), .conduction_sense(conduction_sense_0));
  pwmts_drv_model drv_b (.clk_sys(clk_sys), .rectifier_pwm(rectifier_pwm_1),
    .cond_len(cond_b), .conduction_sense(conduction_sense_1));

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // Cycle count and hang guard, ceiling well above the expected run
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count = bad_count + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // Waits n edges, then settles past the last one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus <= '0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdr(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    d = bus_rdata;
  endtask : rdr

  task automatic rdc(input string n, input logic [3:0] a,
                     input logic [31:0] e);
    rdr(a, rd);
    chk(n, e, rd);
  endtask : rdc

  task automatic t_reset();
    chk("acc_a", 32'h0, {16'h0, edge_adjust_acc_a});
    chk("acc_b", 32'h0, {16'h0, edge_adjust_acc_b});
    rdc("period", ADDR_PERIOD, 32'h3FF);
    wr(ADDR_PERIOD, 32'h7);
    rdc("dtccfg", ADDR_DTCCFG, 32'h1004);
    rdc("thresh", ADDR_THRESH, 32'h010802);
    rdc("adj_a", ADDR_ADJ_A, 32'h0);
    wr(4'hF, 32'hFFFF);
    rdc("unmapped", 4'hF, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_oversample();
    int n;
    int last;
    wr(ADDR_SAMPLE, 32'h1);
    for (int os = 0; os < 4; os++) begin
      wr(ADDR_CTRL, 32'(os));
      tick(16);
      n = 0;
      last = 0;
      for (int i = 0; i < 32; i++) begin
        if (sample_trig === 1'b1) begin
          if (n > 0) chk("trig_gap", 32'(8 >> os), 32'(cyc - last));
          last = cyc;
          n++;
        end
        tick(1);
      end
      chk("trig_count", 32'(4 << os), 32'(n));
    end
    $display("test oversample done");
  endtask : t_oversample

  // Bounded wait for the divided interrupt; start pulse must agree
  task automatic wait_irq();
    int k;
    k = 0;
    tick(1);
    while (period_irq !== 1'b1 && k < 2100) begin
      tick(1);
      k++;
    end
    chk("irq_seen", 32'h1, {31'h0, period_irq});
    chk("conv_start", 32'h1, {31'h0, conv_start});
  endtask : wait_irq

  task automatic t_irq();
    int cnt[15] = '{1, 2, 4, 8, 16, 32, 48, 64, 80, 96, 128, 160, 192,
                    224, 256};
    int t0;
    for (int s = 1; s <= 15; s++) begin
      wr(ADDR_CTRL, 32'(s << CTRL_DIV_LSB));
      wait_irq();
      t0 = cyc;
      wait_irq();
      chk("irq_gap", 32'(8 * cnt[s-1]), 32'(cyc - t0));
    end
    $display("test irq done");
  endtask : t_irq

  // Pulses one sync source just after sync_out; times the next sync_out
  task automatic sync_gap(input logic [3:0] p, input int e);
    int k;
    for (k = 0; k < 20 && (k == 0 || sync_out !== 1'b1); k++) tick(1);
    @(posedge clk_sys);
    sync_src_in <= p;
    @(posedge clk_sys);
    sync_src_in <= 4'h0;
    for (k = 0; k < 20 && (k == 0 || sync_out !== 1'b1); k++) tick(1);
    chk("sync_gap", 32'(e), 32'(k));
  endtask : sync_gap

  task automatic t_sync();
    wr(ADDR_PHASE, 32'h3);
    wr(ADDR_CTRL, (32'h1 << CTRL_SLAVE_BIT) | (32'h1 << CTRL_SRC_LSB));
    rdc("ctrl", ADDR_CTRL, 32'h0C0);
    sync_gap(4'h4, 6);
    sync_gap(4'h2, 4);
    $display("test sync done");
  endtask : t_sync

  task automatic pwm_pulse(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      rectifier_pwm_0 <= 1'b1;
      rectifier_pwm_1 <= 1'b1;
      repeat (10) @(posedge clk_sys);
      rectifier_pwm_0 <= 1'b0;
      rectifier_pwm_1 <= 1'b0;
      tick(40);
    end
  endtask : pwm_pulse

  task automatic chk_acc(input string n, input logic [15:0] a,
                         input logic [15:0] b);
    chk({n, "_a"}, {16'h0, a}, {16'h0, edge_adjust_acc_a});
    chk({n, "_b"}, {16'h0, b}, {16'h0, edge_adjust_acc_b});
  endtask : chk_acc

  task automatic t_dtc();
    logic [31:0] m;
    cond_a = 8'd30;
    cond_b = 8'd0;
    pwm_pulse(3);
    chk_acc("acc_updn", 16'h0003, 16'hFFFD);
    rdr(ADDR_MON, m);
    chk("meas_a_hi", 32'h1, {31'h0, m[11:0] > 12'h008});
    chk("meas_b", 32'h0, {20'h0, m[27:16]});
    wr(ADDR_DTCCFG, 32'h0304);
    wr(ADDR_THRESH, 32'h020605);
    pwm_pulse(1);
    chk_acc("short_win", 16'h0001, 16'hFFFB);
    rdc("meas_clr", ADDR_MON, 32'h4);
    wr(ADDR_THRESH, 32'h02FF00);
    pwm_pulse(1);
    chk_acc("dead_band", 16'h0001, 16'hFFFB);
    wr(ADDR_ADJ_A, 32'h1234);
    chk_acc("auto_wr", 16'h0001, 16'hFFFB);
    wr(ADDR_CTRL, 32'h1 << CTRL_MANUAL_BIT);
    wr(ADDR_ADJ_A, 32'hFFF0);
    cond_b = 8'd30;
    pwm_pulse(1);
    chk_acc("manual", 16'hFFF0, 16'hFFFB);
    rdc("adj_a_rd", ADDR_ADJ_A, 32'h0000FFF0);
    $display("test dead time done");
  endtask : t_dtc

  // Main sequence: reset held 20 cycles, then each scenario
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    tick(1);
    t_reset();
    t_oversample();
    t_irq();
    t_sync();
    t_dtc();
    summarize();
  end
endmodule : tb
